// ---- verilog/hb_cfg_defs.svh ----
`ifndef HB_CFG_DEFS_SVH
`define HB_CFG_DEFS_SVH

// Register offsets on the serial register port
`define OFS_MODE_LOW 8'h0B
`define OFS_MODE_HIGH_GEN 8'h0C
`define OFS_FW_LOW 8'h0D
`define OFS_FW_HIGH 8'h0E
`define OFS_ROUTE_A 8'h0F
`define OFS_ROUTE_B 8'h10
// Field positions
`define POS_GEN_OFF 4
`define POS_MODE_HIGH 0
`define POS_FW_HIGH 0
// Reset values
`define RST_REG 8'h00
`define RST_FW_RSVD 4'h0
`define RST_GEN_EN 4'hF
`define RST_GEN_LIVE 4'h0
`define RST_BRIDGE 12'h000

`endif

// ---- verilog/hb_cfg_pkg.sv ----
package hb_cfg_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [1:0] route_t;

   // Register access from the serial port front end
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Six stored configuration registers
   typedef struct packed {
      byte_t modeLow;
      byte_t modeHighGen;
      byte_t fwLow;
      byte_t fwHigh;
      byte_t routeA;
      byte_t routeB;
   } cfg_regs_t;
endpackage : hb_cfg_pkg

// ---- verilog/hb_bridge_gate.sv ----
`timescale 1ns/100ps
`default_nettype none
// One half-bridge: picks its generator and gates its switch enables
module hb_bridge_gate
(
   // Clocking
   input wire logic clk,
   input wire logic nrst,
   // Configuration
   input wire logic pwmMode,
   input wire logic [1:0] route,
   input wire logic [3:0] genLive,
   input wire logic hsEn,
   input wire logic lsEn,
   // Drive
   output logic hsOn,
   output logic lsOn
);
   typedef struct packed {
      logic hs;
      logic ls;
   } gate_state_t;
   gate_state_t st;
   gate_state_t next_st;
   logic sel;

   // Routed generator level and switch gating
   always_comb
   begin
      sel = genLive[route];
      next_st.hs = hsEn & (~pwmMode | sel);
      next_st.ls = lsEn & (~pwmMode | sel);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         st <= '0;
      else
         st <= next_st;
   end

   assign hsOn = st.hs;
   assign lsOn = st.ls;
endmodule : hb_bridge_gate
`default_nettype wire

// ---- verilog/hb_mode_config.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hb_cfg_defs.svh"
module hb_mode_config
#(
   parameter int BRIDGES = 12,
   parameter int ROUTED = 8
)
(
   // Clocking
   input wire logic clk,
   input wire logic nrst,
   // Register access
   input wire hb_cfg_pkg::reg_req_t req,
   output logic [7:0] rdata,
   output logic rdValid,
   // Generators and switch enables
   input wire logic [3:0] genOut,
   input wire logic [11:0] hsEn,
   input wire logic [11:0] lsEn,
   // Half-bridge drive and configuration
   output logic [11:0] hsOn,
   output logic [11:0] lsOn,
   output logic [11:0] freewheelActive,
   output logic [11:0] pwmMode,
   output logic [3:0] genEnabled
);
   import hb_cfg_pkg::*;

   typedef struct packed {
      cfg_regs_t regs;
      logic [7:0] rdata;
      logic rdValid;
      logic [3:0] genLive;
      logic [3:0] genEn;
      logic [11:0] modeOut;
      logic [11:0] fwOut;
   } state_t;
   // Reset image: registers clear, so every generator reads enabled
   localparam state_t ST_RESET = '{
      regs: '{default: `RST_REG},
      rdata: `RST_REG,
      rdValid: 1'b0,
      genLive: `RST_GEN_LIVE,
      genEn: `RST_GEN_EN,
      modeOut: `RST_BRIDGE,
      fwOut: `RST_BRIDGE
   };
   state_t st;
   state_t next_st;
   logic [11:0] modeVec;
   logic [11:0] fwVec;
   logic [15:0] routeVec;

   // Register writes, reads and generator gating
   always_comb
   begin
      next_st = st;
      next_st.rdValid = req.rdEn;
      if (req.wrEn)
      begin
         case (req.addr)
            `OFS_MODE_LOW: next_st.regs.modeLow = req.wdata;
            `OFS_MODE_HIGH_GEN: next_st.regs.modeHighGen = req.wdata;
            `OFS_FW_LOW: next_st.regs.fwLow = req.wdata;
            `OFS_FW_HIGH: next_st.regs.fwHigh = req.wdata;
            `OFS_ROUTE_A: next_st.regs.routeA = req.wdata;
            `OFS_ROUTE_B: next_st.regs.routeB = req.wdata;
            default: next_st.regs = st.regs;
         endcase
      end
      if (req.rdEn)
      begin
         case (req.addr)
            `OFS_MODE_LOW: next_st.rdata = st.regs.modeLow;
            `OFS_MODE_HIGH_GEN: next_st.rdata = st.regs.modeHighGen;
            `OFS_FW_LOW: next_st.rdata = st.regs.fwLow;
            `OFS_FW_HIGH: next_st.rdata = st.regs.fwHigh;
            `OFS_ROUTE_A: next_st.rdata = st.regs.routeA;
            `OFS_ROUTE_B: next_st.rdata = st.regs.routeB;
            default: next_st.rdata = `RST_REG;
         endcase
      end
      // Disabled generators forced low
      next_st.genLive = genOut & ~st.regs.modeHighGen[`POS_GEN_OFF +: 4];
      // Registered configuration outputs
      next_st.genEn = ~next_st.regs.modeHighGen[`POS_GEN_OFF +: 4];
      next_st.modeOut = modeVec;
      next_st.fwOut = fwVec;
   end

   // All registers clear on reset except genEn, which loads 4'hF
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         st <= ST_RESET;
      else
         st <= next_st;
   end

   assign modeVec = {st.regs.modeHighGen[`POS_MODE_HIGH +: 4], st.regs.modeLow};
   assign fwVec = {st.regs.fwHigh[`POS_FW_HIGH +: 4], st.regs.fwLow};
   assign routeVec = {st.regs.routeB, st.regs.routeA};
   assign rdata = st.rdata;
   assign rdValid = st.rdValid;
   assign genEnabled = st.genEn;
   assign pwmMode = st.modeOut;
   assign freewheelActive = st.fwOut;

   // Per-bridge gating, configuration registered outputs
   genvar g;
   generate
      for (g = 0; g < BRIDGES; g++)
      begin : gBridge
         logic [1:0] rt;
         // Bridges beyond the routed set use generator 1
         if (g < ROUTED)
         begin : gRouted
            assign rt = routeVec[2*g +: 2];
         end
         else
         begin : gFixed
            assign rt = 2'h0;
         end
         hb_bridge_gate uGate
         (
            .clk(clk),
            .nrst(nrst),
            .pwmMode(modeVec[g]),
            .route(rt),
            .genLive(st.genLive),
            .hsEn(hsEn[g]),
            .lsEn(lsEn[g]),
            .hsOn(hsOn[g]),
            .lsOn(lsOn[g])
         );
      end
   endgenerate

   // Write strobes that start the multi-step paths below
   sequence modeLowWr_s;
      req.wrEn && req.addr == `OFS_MODE_LOW;
   endsequence
   sequence fwHighWr_s;
      req.wrEn && req.addr == `OFS_FW_HIGH;
   endsequence
   sequence routeBWr_s;
      req.wrEn && req.addr == `OFS_ROUTE_B;
   endsequence
   // Strobes outside the six mapped offsets
   sequence unmappedWr_s;
      req.wrEn && (req.addr < `OFS_MODE_LOW || req.addr > `OFS_ROUTE_B);
   endsequence
   sequence unmappedRd_s;
      req.rdEn && (req.addr < `OFS_MODE_LOW || req.addr > `OFS_ROUTE_B);
   endsequence

   // Write lands one cycle later
   regWrite_a: assert property (@(posedge clk) disable iff (!nrst)
      modeLowWr_s |=> st.regs.modeLow == $past(req.wdata))
      else $error("mode low write lost");
   genOff_a: assert property (@(posedge clk) disable iff (!nrst)
      st.regs.modeHighGen[4] |=> !st.genLive[0])
      else $error("disabled generator live");
   contMode_a: assert property (@(posedge clk) disable iff (!nrst)
      !modeVec[0] && hsEn[0] |=> hsOn[0])
      else $error("continuous switch not on");
   readBack_a: assert property (@(posedge clk) disable iff (!nrst)
      req.rdEn && req.addr == `OFS_ROUTE_B |=> rdValid && rdata == $past(st.regs.routeB))
      else $error("route b readback wrong");
   unmapped_a: assert property (@(posedge clk) disable iff (!nrst)
      unmappedRd_s |=> rdata == `RST_REG)
      else $error("unmapped read nonzero");
   fwOut_a: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> freewheelActive[11] == $past(st.regs.fwHigh[3]))
      else $error("freewheel bridge 12 wrong");
   modeOut_a: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> pwmMode[8] == $past(st.regs.modeHighGen[0]))
      else $error("mode bridge 9 wrong");
   fwLow_a: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> freewheelActive[0] == $past(st.regs.fwLow[0]))
      else $error("freewheel bridge 1 wrong");

   // Strobe, register, then mode output two cycles on
   modeLowOut_a: assert property (@(posedge clk) disable iff (!nrst)
      modeLowWr_s |=> ##1 pwmMode[7:0] == $past(req.wdata, 2))
      else $error("mode low output wrong");
   fwHighWrite_a: assert property (@(posedge clk) disable iff (!nrst)
      fwHighWr_s |=> st.regs.fwHigh == $past(req.wdata))
      else $error("freewheel high write lost");
   routeBWrite_a: assert property (@(posedge clk) disable iff (!nrst)
      routeBWr_s |=> st.regs.routeB == $past(req.wdata))
      else $error("route b write lost");
   noWrite_a: assert property (@(posedge clk) disable iff (!nrst)
      unmappedWr_s |=> $stable(st.regs))
      else $error("unmapped write changed registers");
   genEn_a: assert property (@(posedge clk) disable iff (!nrst)
      genEnabled == ~st.regs.modeHighGen[`POS_GEN_OFF +: 4])
      else $error("generator enable wrong");

   // PWM gating of routed bridges and of fixed-route bridge 9
   pwmGate_a: assert property (@(posedge clk) disable iff (!nrst)
      modeVec[0] && !st.genLive[routeVec[1:0]] |=> !hsOn[0] && !lsOn[0])
      else $error("pwm bridge 1 not gated");
   pwmOn_a: assert property (@(posedge clk) disable iff (!nrst)
      modeVec[4] && hsEn[4] && st.genLive[routeVec[9:8]] |=> hsOn[4])
      else $error("pwm bridge 5 not driven");
   fixedRoute_a: assert property (@(posedge clk) disable iff (!nrst)
      modeVec[8] && lsEn[8] |=> lsOn[8] == $past(st.genLive[0]))
      else $error("bridge 9 not on generator 1");

   // Read answer: one-cycle valid, data held between reads
   rdPulse_a: assert property (@(posedge clk) disable iff (!nrst)
      !req.rdEn |=> !rdValid)
      else $error("read valid longer than one cycle");
   rdHold_a: assert property (@(posedge clk) disable iff (!nrst)
      !req.rdEn |=> $stable(rdata))
      else $error("read data changed without read");
endmodule : hb_mode_config
`default_nettype wire

// ---- verif/hb_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Register host: one-cycle strobes launched on the falling edge
module hb_host_model
(
   // Clocking
   input wire logic clk,
   // Register access
   output var hb_cfg_pkg::reg_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rdValid
);
   import hb_cfg_pkg::*;
   // Idle bus at time zero
   initial req = '0;
   // One access; a read answer is taken a cycle after the strobe
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic v);
      @(negedge clk);
      req = '{wrEn: wr, rdEn: !wr, addr: a, wdata: d};
      @(negedge clk);
      q = rdata;
      v = rdValid;
      req = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
   endtask : xfer
endmodule : hb_host_model
`default_nettype wire

// ---- verif/hb_mode_config_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module hb_mode_config_tb_top;
   import hb_cfg_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   reg_req_t req;
   logic [7:0] rdata, q;
   logic rdValid, v;
   logic [3:0] genOut = 4'h0, genEnabled;
   logic [11:0] hsEn = 12'h000, lsEn = 12'h000, hsOn, lsOn, freewheelActive, pwmMode;
   logic [7:0] m[6];
   int a;
   int fail_count = 0;
   int cmp_count = 0;
   // Clock, 8 ns period
   always #4 clk = ~clk;
   hb_host_model host_u (.clk(clk), .req(req), .rdata(rdata), .rdValid(rdValid));
   hb_mode_config dut_u (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
      .rdValid(rdValid), .genOut(genOut), .hsEn(hsEn), .lsEn(lsEn), .hsOn(hsOn),
      .lsOn(lsOn), .freewheelActive(freewheelActive), .pwmMode(pwmMode),
      .genEnabled(genEnabled));
   // Compare and count
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Expected drive and configuration from the register model
   task automatic check_outs();
      logic [11:0] pw, hs, ls;
      logic [3:0] live, en;
      int g;
      pw = {m[1][3:0], m[0]};
      live = genOut & ~m[1][7:4];
      en = ~m[1][7:4];
      for (int b = 0; b < 12; b++)
      begin
         g = (b < 8) ? (m[4 + b / 4] >> (2 * (b % 4))) & 3 : 0;
         hs[b] = hsEn[b] & (!pw[b] | live[g]);
         ls[b] = lsEn[b] & (!pw[b] | live[g]);
      end
      check(pwmMode, pw);
      check(freewheelActive, {m[3][3:0], m[2]});
      check(genEnabled, en);
      check(hsOn, hs);
      check(lsOn, ls);
   endtask : check_outs
   // Verdict
   task automatic finish_test();
      $display("cmp_count=%0d fail_count=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   // Watchdog
   initial
   begin
      #20000;
      fail_count++;
      finish_test();
   end
   // Main sequence
   initial
   begin
      void'($urandom(32'h2691));
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      // Reset values of every register
      for (int i = 0; i < 6; i++)
      begin
         m[i] = 8'h00;
         host_u.xfer(1'b0, 8'(8'h0B + i), 8'h00, q, v);
         check(q, 8'h00);
         check(v, 1'b1);
      end
      check_outs();
      // Unmapped place: write ignored, read zero
      host_u.xfer(1'b1, 8'h11, 8'hFF, q, v);
      host_u.xfer(1'b0, 8'h11, 8'h00, q, v);
      check(q, 8'h00);
      check(v, 1'b1);
      check_outs();
      // Random writes, read-back and drive check
      repeat (40)
      begin
         a = $urandom_range(5);
         m[a] = 8'($urandom);
         host_u.xfer(1'b1, 8'(8'h0B + a), m[a], q, v);
         host_u.xfer(1'b0, 8'(8'h0B + a), 8'h00, q, v);
         check(q, m[a]);
         genOut = 4'($urandom);
         hsEn = 12'($urandom);
         lsEn = 12'($urandom);
         repeat (3) @(negedge clk);
         check_outs();
      end
      // Reset in mid-run
      nrst = 1'b0;
      @(negedge clk);
      check(genEnabled, 4'hF);
      check(pwmMode, 12'h000);
      check(hsOn, 12'h000);
      check(freewheelActive, 12'h000);
      check(rdValid, 1'b0);
      nrst = 1'b1;
      m = '{default: 8'h00};
      repeat (3) @(negedge clk);
      check_outs();
      host_u.xfer(1'b0, 8'h0C, 8'h00, q, v);
      check(q, 8'h00);
      check(v, 1'b1);
      finish_test();
   end
endmodule : hb_mode_config_tb_top
`default_nettype wire
